/* src/ramap_top.sv */
// relay and analog output mapper: three function-selected relays and one analog output
// assumes controller status flags and measurements are synchronous to clk
//
// What this block does
// - unassigned relay follows bus-written manual bit only
// - fault fail-safe: on unless any fault
// - fault non-fail-safe: on only while faulted
// - interlock fail-safe: on when ready; relay one default
// - interlock non-fail-safe: on when not ready
// - running function follows motor running; relay three default
// - synced function on while synchronism holds
// - inching, and inching with expired up-to-speed timer
// - alarm function on for any alarm
// - ready function on when start accepted
// - over and undercurrent functions follow alarms
// - shunt fail-safe: on unless shunt trip fault
// - shunt non-fail-safe: on only on shunt fault
// - field apply and discharge contactors; relay two default
// - field aux needs sync and expired delay
// - dynamic brake function drives brake contactor
// - three relays, each with own selector
// - aux delay off or 0.1-90.0 s, resets off
// - delay counts up in tenths after sync, then energizes
// - analog selected source, default off, refreshed 25 ms
// - current scales 0-200%, voltage 0-150%
// - slip reads 100% stopped, 0% full speed
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
module ramap_top
   import ramap_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire ramap_status_t status_in,
   input wire ramap_meas_t meas_in,
   output logic [2:0] relay_coil,
   output logic [11:0] analog_out
);

   logic [4:0] relay_fn_q [3];
   logic [2:0] relay_manual_q;
   logic [9:0] aux_delay_q;
   ramap_analog_fn_t analog_fn_q;
   logic ack_q;
   logic [9:0] aux_tenths_q;
   logic [23:0] aux_tick_q;
   logic aux_done_q;
   logic [21:0] aout_tick_q;
   logic [2:0] relay_d;
   logic [11:0] aout_d;
   logic [31:0] rdata_d;
   logic req;
   logic [4:0] fn_wr [3];

   // one wait cycle per access keeps readdata and waitrequest both registered
   assign req = (avs_read | avs_write) & ~ack_q;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~req;
      end
   end

   // config register: relay n function at bits 8n+4..8n, manual bits at 26..24
   // manual bits sit in their own byte so a function write with byte 3 disabled never disturbs them
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         relay_fn_q[0] <= RELAY1_FN_RST;
         relay_fn_q[1] <= RELAY2_FN_RST;
         relay_fn_q[2] <= RELAY3_FN_RST;
         relay_manual_q <= 3'h0;
      end else if (req && avs_write && avs_address == RELAY_CFG_OFS) begin
         for (int i = 0; i < 3; i++) begin
            if (avs_byteenable[i] && fn_wr[i] <= 5'(RF_COOL_FAN)) begin
               relay_fn_q[i] <= fn_wr[i];
            end
         end
         if (avs_byteenable[3]) begin
            relay_manual_q <= avs_writedata[RELAY_MANUAL_POS +: 3];
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         fn_wr[i] = avs_writedata[8*i +: RELAY_FN_W];
      end
   end

   // out-of-range delays are ignored so the setting stays off or 0.1-90.0 s
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         aux_delay_q <= AUX_DELAY_OFF;
      end else if (req && avs_write && avs_address == AUX_DELAY_OFS && (&avs_byteenable[1:0])) begin
         if (avs_writedata[9:0] <= AUX_DELAY_MAX && avs_writedata[15:10] == 6'h00) begin
            aux_delay_q <= avs_writedata[9:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         analog_fn_q <= AF_OFF;
      end else if (req && avs_write && avs_address == ANALOG_FN_OFS && avs_byteenable[0]) begin
         if (avs_writedata[2:0] <= 3'(AF_CALIB)) begin
            analog_fn_q <= ramap_analog_fn_t'(avs_writedata[2:0]);
         end
      end
   end

   always_comb begin
      rdata_d = 32'h0000_0000;
      if (avs_address == RELAY_CFG_OFS) begin
         for (int i = 0; i < 3; i++) begin
            rdata_d[8*i +: RELAY_FN_W] = relay_fn_q[i];
         end
         rdata_d[RELAY_MANUAL_POS +: 3] = relay_manual_q;
      end else if (avs_address == AUX_DELAY_OFS) begin
         rdata_d[9:0] = aux_delay_q;
      end else if (avs_address == ANALOG_FN_OFS) begin
         rdata_d[2:0] = analog_fn_q;
      end else if (avs_address == STATUS_OFS) begin
         rdata_d[2:0] = relay_coil;
         rdata_d[3] = aux_done_q;
         rdata_d[27:16] = analog_out;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         avs_readdata <= 32'h0000_0000;
      end else if (req && avs_read) begin
         avs_readdata <= rdata_d;
      end
   end

   // aux delay: counts tenths of a second while synchronised; loss of sync restarts
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         aux_tick_q <= 24'h000000;
         aux_tenths_q <= 10'h000;
         aux_done_q <= 1'b0;
      end else if (!status_in.synced || aux_delay_q == AUX_DELAY_OFF) begin
         aux_tick_q <= 24'h000000;
         aux_tenths_q <= 10'h000;
         aux_done_q <= 1'b0;
      end else if (!aux_done_q) begin
         if (aux_tick_q == 24'(TENTH_SEC_CYC - 1)) begin
            aux_tick_q <= 24'h000000;
            aux_tenths_q <= aux_tenths_q + 10'h001;
            if (aux_tenths_q + 10'h001 >= aux_delay_q) begin
               aux_done_q <= 1'b1;
            end
         end else begin
            aux_tick_q <= aux_tick_q + 24'h000001;
         end
      end
   end

   function automatic logic relay_level(input logic [4:0] fn, input logic manual,
                                        input ramap_status_t s, input logic aux_done);
      logic lvl;
      lvl = 1'b0;
      case (fn)
         5'(RF_OFF): lvl = manual;
         5'(RF_FAULT_FS): lvl = ~s.fault;
         5'(RF_FAULT_NFS): lvl = s.fault;
         5'(RF_ILOCK_FS): lvl = s.ready;
         5'(RF_ILOCK_NFS): lvl = ~s.ready;
         5'(RF_RUNNING): lvl = s.running;
         5'(RF_SYNCED): lvl = s.synced;
         5'(RF_INCHING): lvl = s.inching;
         5'(RF_INCHING_UP_TO_SPEED_FUNCTION): lvl = s.inching & s.inching_up_to_speed_function_done;
         5'(RF_ALARM): lvl = s.alarm;
         5'(RF_READY): lvl = s.ready;
         5'(RF_LOCKED_OUT): lvl = s.locked_out;
         5'(RF_OVERCURRENT): lvl = s.overcurrent;
         5'(RF_UNDERCURRENT): lvl = s.undercurrent;
         5'(RF_SHUNT_FS): lvl = ~s.shunt_fault;
         5'(RF_SHUNT_NFS): lvl = s.shunt_fault;
         5'(RF_FIELD_APPLY): lvl = s.field_apply;
         5'(RF_FIELD_DISCHARGE): lvl = s.field_discharge;
         5'(RF_FIELD_AUX): lvl = s.synced & aux_done;
         5'(RF_DYN_BRAKE): lvl = s.dyn_brake;
         5'(RF_COOL_FAN): lvl = s.fan_on;
         default: lvl = 1'b0;
      endcase
      return lvl;
   endfunction

   generate
      for (genvar g = 0; g < 3; g++) begin : g_relay
         assign relay_d[g] = relay_level(relay_fn_q[g], relay_manual_q[g], status_in, aux_done_q);
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         relay_coil <= 3'h0;
      end else begin
         relay_coil <= relay_d;
      end
   end

   function automatic logic [11:0] scale(input logic [15:0] val, input logic [15:0] span);
      logic [27:0] prod;
      prod = 28'(val >= span ? span : val) * 28'(AOUT_FULL);
      return 12'(prod / 28'(span));
   endfunction

   always_comb begin
      aout_d = 12'h000;
      case (analog_fn_q)
         AF_OFF: aout_d = 12'h000;
         AF_CURRENT: aout_d = scale(meas_in.current_pct, CURR_SPAN_PCT);
         AF_VOLTAGE: aout_d = scale(meas_in.voltage_pct, VOLT_SPAN_PCT);
         AF_SLIP: aout_d = AOUT_FULL - scale(meas_in.speed_pct, SPEED_FULL_PCT);
         AF_AIN: aout_d = scale(meas_in.ain_pct, SPEED_FULL_PCT);
         AF_FIRING: aout_d = scale(meas_in.firing_pct, SPEED_FULL_PCT);
         AF_CALIB: aout_d = AOUT_FULL;
         default: aout_d = 12'h000;
      endcase
   end

   // output is sampled only on the refresh tick so it steps every 25 ms
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         aout_tick_q <= 22'h000000;
         analog_out <= 12'h000;
      end else if (aout_tick_q == 22'(AOUT_PERIOD_CYC - 1)) begin
         aout_tick_q <= 22'h000000;
         analog_out <= aout_d;
      end else begin
         aout_tick_q <= aout_tick_q + 22'h000001;
      end
   end

endmodule

/* src/ramap_pkg.sv */
// package for the relay and analog output mapper: register map, codes, timing
// assumes a 125 MHz clock and 32-bit avalon-mm register access
package ramap_pkg;

   localparam int unsigned CLK_HZ = 125000000;
   localparam int unsigned TENTH_SEC_CYC = CLK_HZ / 10;
   localparam int unsigned AOUT_PERIOD_MS = 25;
   localparam int unsigned AOUT_PERIOD_CYC = CLK_HZ / 1000 * AOUT_PERIOD_MS;

   // register byte offsets
   localparam logic [3:0] RELAY_CFG_OFS = 4'h0;
   localparam logic [3:0] AUX_DELAY_OFS = 4'h4;
   localparam logic [3:0] ANALOG_FN_OFS = 4'h8;
   localparam logic [3:0] STATUS_OFS = 4'hC;

   // relay function codes, five bits per relay in the config register
   typedef enum logic [4:0] {
      RF_OFF, RF_FAULT_FS, RF_FAULT_NFS, RF_ILOCK_FS, RF_ILOCK_NFS, RF_RUNNING,
      RF_SYNCED, RF_INCHING, RF_INCHING_UP_TO_SPEED_FUNCTION, RF_ALARM, RF_READY, RF_LOCKED_OUT,
      RF_OVERCURRENT, RF_UNDERCURRENT, RF_SHUNT_FS, RF_SHUNT_NFS,
      RF_FIELD_APPLY, RF_FIELD_DISCHARGE, RF_FIELD_AUX, RF_DYN_BRAKE, RF_COOL_FAN
   } ramap_relay_fn_t;

   localparam int unsigned RELAY_FN_W = 5;
   localparam int unsigned RELAY_MANUAL_POS = 24;
   localparam logic [4:0] RELAY1_FN_RST = 5'h03;
   localparam logic [4:0] RELAY2_FN_RST = 5'h10;
   localparam logic [4:0] RELAY3_FN_RST = 5'h05;

   // aux delay in tenths of seconds, zero means off
   localparam logic [9:0] AUX_DELAY_OFF = 10'h000;
   localparam logic [9:0] AUX_DELAY_MAX = 10'h384;

   typedef enum logic [2:0] {
      AF_OFF, AF_CURRENT, AF_VOLTAGE, AF_SLIP, AF_AIN, AF_FIRING, AF_CALIB
   } ramap_analog_fn_t;

   localparam logic [11:0] AOUT_FULL = 12'hFFF;
   localparam logic [15:0] CURR_SPAN_PCT = 16'h00C8;
   localparam logic [15:0] VOLT_SPAN_PCT = 16'h0096;
   localparam logic [15:0] SPEED_FULL_PCT = 16'h0064;

   typedef struct packed {
      logic fault;
      logic ready;
      logic running;
      logic synced;
      logic inching;
      logic inching_up_to_speed_function_done;
      logic alarm;
      logic locked_out;
      logic overcurrent;
      logic undercurrent;
      logic shunt_fault;
      logic field_apply;
      logic field_discharge;
      logic dyn_brake;
      logic fan_on;
   } ramap_status_t;

   // measurements in percent of rated value
   typedef struct packed {
      logic [15:0] current_pct;
      logic [15:0] voltage_pct;
      logic [15:0] speed_pct;
      logic [15:0] ain_pct;
      logic [15:0] firing_pct;
   } ramap_meas_t;

endpackage

/* verification/ramap_chk_asserts.sv */
// port checker for the relay and analog output mapper
// assumes it is bound to ramap_top, one clock, sync reset rst_b
module ramap_chk
   import ramap_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire ramap_status_t status_in,
   input wire logic [2:0] relay_coil,
   input wire logic [11:0] analog_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic dflt_q;
   logic keep;
   logic [31:0] age_q;
   // a pending config write ends the default mapping one edge early
   assign keep = dflt_q && !(avs_write && avs_address == RELAY_CFG_OFS);
   always_ff @(posedge clk) begin
      if (!rst_b) dflt_q <= 1'b1;
      else if (!keep) dflt_q <= 1'b0;
   end
   always_ff @(posedge clk) begin
      if (!rst_b || !$stable(analog_out)) age_q <= '0;
      else if (age_q != '1) age_q <= age_q + 1;
   end
   wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("ack too long");
   bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("no ack");
   ack_req_a: assert property (!avs_waitrequest |-> avs_read || avs_write) else $error("stray ack");
   rst_val_a: assert property ($rose(rst_b) |-> relay_coil == 3'h0 && analog_out == 12'h000)
      else $error("bad reset");
   relay_one_a: assert property (keep |=> relay_coil[0] == $past(status_in.ready))
      else $error("relay one");
   relay_two_a: assert property (keep |=> relay_coil[1] == $past(status_in.field_apply))
      else $error("relay two");
   relay_three_a: assert property (keep |=> relay_coil[2] == $past(status_in.running))
      else $error("relay three");
   unmapped_rd_a: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
      |-> avs_readdata == 32'h0) else $error("unmapped read");
   aout_hold_a: assert property (!$stable(analog_out) |-> age_q >= AOUT_PERIOD_CYC - 1)
      else $error("early refresh");
   cover property (avs_write && !avs_waitrequest);
   cover property (relay_coil == 3'h7);
   cover property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0);
endmodule
bind ramap_top ramap_chk u_ramap_chk (.clk, .rst_b, .avs_address, .avs_read, .avs_write,
   .avs_readdata, .avs_waitrequest, .status_in, .relay_coil, .analog_out);

/* verification/ramap_load_model.sv */
// contactors pulled in by the relays and the analog receiver
// assumes coil and analog levels from ramap_top on the same clock
module ramap_load_model
   import ramap_pkg::*;
#(
   parameter int unsigned PULL_CYC = 4
)
(
   input wire logic clk,
   input wire logic [2:0] relay_coil,
   input wire logic [11:0] analog_out,
   output logic [2:0] contact_closed,
   output logic [11:0] aout_level
);
   logic [2:0] pipe_q [PULL_CYC];
   // armature travel: contacts lag the coil by a few cycles
   always_ff @(posedge clk) begin
      pipe_q[0] <= relay_coil;
      for (int i = 1; i < PULL_CYC; i++) pipe_q[i] <= pipe_q[i-1];
   end
   assign contact_closed = pipe_q[PULL_CYC-1];
   always_ff @(posedge clk) aout_level <= analog_out;
endmodule

/* verification/relay_and_analog_output_mapper_test.sv */
// self-checking bench for ramap_top with a contactor model
// assumes the fixed 125 MHz timing of ramap_pkg
module relay_and_analog_output_mapper_test
   import ramap_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   ramap_status_t status_in = '0;
   ramap_meas_t meas_in = {5{16'h0032}};
   logic [2:0] relay_coil;
   logic [11:0] analog_out;
   logic [2:0] contact_closed;
   int n_mismatch = 0;
   int checks_done = 0;
   always #4 clk = ~clk;
   ramap_top u_ramap_top (.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .status_in, .meas_in, .relay_coil, .analog_out);
   ramap_load_model u_ramap_load_model (.clk, .relay_coil, .analog_out, .contact_closed, .aout_level());
   task final_report;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // entered just after an edge, leaves one idle edge behind
   task bus(input logic rd, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
      output logic [31:0] q);
      int n;
      n = 0;
      avs_read <= rd;
      avs_write <= !rd;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 40) begin
         n_mismatch++;
         final_report;
      end
      @(posedge clk);
   endtask
   task settle(input ramap_status_t s, input logic [2:0] exp);
      status_in <= s;
      repeat (2) @(posedge clk);
      chk(32'(relay_coil), 32'(exp));
   endtask
   task t_defaults;
      logic [31:0] q;
      ramap_status_t s;
      bus(1'b1, RELAY_CFG_OFS, 32'h0, 4'hF, q);
      chk(q, {11'h0, RF_RUNNING, 3'h0, RF_FIELD_APPLY, 3'h0, RF_ILOCK_FS});
      bus(1'b1, AUX_DELAY_OFS, 32'h0, 4'hF, q);
      chk(q, 32'h0);
      bus(1'b1, ANALOG_FN_OFS, 32'h0, 4'hF, q);
      chk(q, 32'h0);
      s = '0;
      s.ready = 1'b1;
      s.running = 1'b1;
      settle(s, 3'b101);
      s = '0;
      s.field_apply = 1'b1;
      settle(s, 3'b010);
      repeat (6) @(posedge clk);
      chk(32'(contact_closed), 32'h2);
   endtask
   // all-clear then all-set status, every function code on all relays
   task t_codes;
      logic [31:0] q;
      logic [4:0] c;
      logic lo;
      logic hi;
      ramap_status_t s;
      for (int i = 0; i <= 20; i++) begin
         c = 5'(i);
         lo = c == RF_FAULT_FS || c == RF_ILOCK_NFS || c == RF_SHUNT_FS;
         hi = !lo && c != RF_OFF && c != RF_FIELD_AUX;
         bus(1'b0, RELAY_CFG_OFS, {11'h0, c, 3'h0, c, 3'h0, c}, 4'h7, q);
         settle('0, {3{lo}});
         settle('1, {3{hi}});
      end
      bus(1'b0, RELAY_CFG_OFS, {11'h0, RF_SYNCED, 3'h0, RF_INCHING, 3'h0, RF_INCHING_UP_TO_SPEED_FUNCTION}, 4'h7, q);
      s = '0;
      s.inching = 1'b1;
      settle(s, 3'b010);
      s = '0;
      s.synced = 1'b1;
      settle(s, 3'b100);
   endtask
   task t_refused;
      logic [31:0] q;
      bus(1'b0, RELAY_CFG_OFS, 32'h15, 4'h1, q);
      bus(1'b1, RELAY_CFG_OFS, 32'h0, 4'hF, q);
      chk(q, {11'h0, RF_SYNCED, 3'h0, RF_INCHING, 3'h0, RF_INCHING_UP_TO_SPEED_FUNCTION});
      bus(1'b0, AUX_DELAY_OFS, 32'h385, 4'h3, q);
      bus(1'b1, AUX_DELAY_OFS, 32'h0, 4'hF, q);
      chk(q, 32'h0);
      bus(1'b0, AUX_DELAY_OFS, 32'h384, 4'h3, q);
      bus(1'b1, AUX_DELAY_OFS, 32'h0, 4'hF, q);
      chk(q, 32'h384);
      for (int i = 1; i <= 7; i++) begin
         bus(1'b0, ANALOG_FN_OFS, 32'(i), 4'hF, q);
         bus(1'b1, ANALOG_FN_OFS, 32'h0, 4'hF, q);
         chk(q, (i == 7) ? 32'h6 : 32'(i));
      end
      bus(1'b0, 4'h2, 32'hFFFFFFFF, 4'hF, q);
      bus(1'b1, 4'h2, 32'h0, 4'hF, q);
      chk(q, 32'h0);
      chk(32'(analog_out), 32'h0);
      // unassigned relays follow the manual bits written in the top byte
      bus(1'b0, RELAY_CFG_OFS, 32'h0700_0000, 4'hF, q);
      bus(1'b1, RELAY_CFG_OFS, 32'h0, 4'hF, q);
      chk(q, 32'h0700_0000);
      settle('0, 3'b111);
      settle('1, 3'b111);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_defaults;
      t_codes;
      t_refused;
      final_report;
   end
endmodule
